// ### verilog/switch_onto_fault_pkg.sv
package switch_onto_fault_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] EVT_SEL_OFS = 8'h08;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h0c;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
   localparam logic [7:0] TIME_MS_OFS = 8'h14;
   localparam logic [7:0] LOG_SEL_OFS = 8'h18;
   localparam logic [7:0] LOG_STAMP_OFS = 8'h1c;
   localparam logic [7:0] LOG_REMAIN_OFS = 8'h20;
   localparam logic [7:0] LOG_ELAPSED_OFS = 8'h24;
   localparam logic [7:0] CNT_BASE_OFS = 8'h28;
   localparam logic [7:0] CNT_LAST_OFS = 8'h34;
   localparam logic [7:0] REL_BASE_OFS = 8'h40;
   localparam logic [7:0] REL_LAST_OFS = 8'h5c;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_MODE_ALLOW_BIT = 0;
   localparam int CTRL_FORCE_EN_BIT = 1;
   localparam int CTRL_MODE_LSB = 2;
   localparam int CTRL_FORCE_LSB = 5;
   localparam int CTRL_CNT_CLR_BIT = 8;
   localparam int CTRL_LOG_CLR_BIT = 9;
   localparam int STATUS_MODE_LSB = 4;
   localparam int STATUS_FLAG_LSB = 8;
   localparam int LOG_GROUP_LSB = 8;
   localparam int LOG_TRIP_BIT = 12;
   localparam int LOG_COUNT_LSB = 16;
   localparam int ST_INIT = 0;
   localparam int ST_BLOCK = 1;
   localparam int ST_ACTIVE = 2;
   localparam int ST_TRIP = 3;

   // ----------------------------------------------------------------
   // Sizes, reset values and timing
   // ----------------------------------------------------------------
   localparam int NUM_STATUS = 4;
   localparam int NUM_GROUPS = 8;
   localparam int REL_W = 21;
   localparam int STAMP_W = 32;
   localparam int LOG_DEPTH_DEF = 12;
   localparam logic [9:0] CTRL_RESET = 10'h000;
   localparam logic [7:0] EVT_SEL_RESET = 8'hff;
   localparam logic [REL_W-1:0] REL_TIME_RESET_MS = 21'd1000;
   localparam logic [REL_W-1:0] REL_TIME_MAX_MS = 21'd1800000;
   localparam int MS_PERIOD_NS = 1000000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_TICK_CYCLES_DEF = MS_PERIOD_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      MODE_ON = 3'b000,
      MODE_BLOCKED = 3'b001,
      MODE_TEST = 3'b010,
      MODE_TEST_BLOCKED = 3'b011,
      MODE_OFF = 3'b100
   } mode_t;

   typedef enum logic [2:0] {
      COND_NORMAL = 3'b000,
      COND_INIT = 3'b001,
      COND_ACTIVE = 3'b010,
      COND_TRIP = 3'b011,
      COND_BLOCKED = 3'b100
   } cond_t;

   typedef enum logic [1:0] {
      FORCE_NORMAL = 2'b00,
      FORCE_BLOCKED = 2'b01,
      FORCE_ACTIVE = 2'b10,
      FORCE_TRIP = 2'b11
   } force_t;

   typedef enum logic [1:0] {
      WIN_IDLE = 2'b00,
      WIN_ARMED = 2'b01,
      WIN_TRIP = 2'b10
   } win_t;

endpackage : switch_onto_fault_pkg

// ### verilog/record_log.sv
`timescale 1ns/100ps
module record_log #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 12
) (
   input logic pclk,
   input logic presetn,
   input logic push,
   input logic [WIDTH-1:0] push_data,
   input logic clear,
   input logic [3:0] rd_index,
   output logic [WIDTH-1:0] rd_data,
   output logic [$clog2(DEPTH+1)-1:0] count
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] head_reg;
   logic [CW-1:0] count_reg;
   logic [PW-1:0] rd_addr;
   int a;

   // Index zero is always the newest record.
   always_comb begin
      a = int'(head_reg) - 1 - int'(rd_index);
      if (a < 0) begin
         a = a + DEPTH;
      end
      rd_addr = PW'(a);
   end

   // The oldest slot is overwritten once the ring is full.
   always_ff @(posedge pclk) begin
      if (push) begin
         mem[head_reg] <= push_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         head_reg <= '0;
         count_reg <= '0;
      end else if (clear) begin
         head_reg <= '0;
         count_reg <= '0;
      end else if (push) begin
         head_reg <= (head_reg == PW'(DEPTH - 1)) ? '0 : head_reg + 1'b1;
         if (count_reg != CW'(DEPTH)) begin
            count_reg <= count_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '0;
      end else begin
         rd_data <= (CW'(rd_index) < count_reg) ? mem[rd_addr] : '0;
      end
   end

   assign count = count_reg;

   log_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
      push && !clear && count_reg == CW'(DEPTH) |=> count_reg == CW'(DEPTH))
      else $error("Record count left its ceiling.");

endmodule : record_log

// ### verilog/switch_onto_fault.sv
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module switch_onto_fault
   import switch_onto_fault_pkg::*;
#(
   parameter int unsigned MS_TICK_CYCLES = MS_TICK_CYCLES_DEF,
   parameter int LOG_DEPTH = LOG_DEPTH_DEF
) (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input logic arm_input_signal,
   input logic inhibit_input_signal,
   input logic protection_start_input,
   input logic [2:0] setting_group,
   output logic window_active_flag,
   output logic instant_trip_output,
   output logic [2:0] block_condition_state,
   output logic [2:0] block_mode_readback,
   output logic [REL_W-1:0] remaining_window_time,
   output logic [7:0] event_strobe,
   output logic [STAMP_W-1:0] event_stamp
);

   localparam int TICK_W = $clog2(MS_TICK_CYCLES + 1);
   localparam int REC_W = STAMP_W + 4 + 2 * REL_W;
   localparam int CW = $clog2(LOG_DEPTH + 1);

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a[1:0] == 2'b00) && (a <= LOG_ELAPSED_OFS ||
         (a >= CNT_BASE_OFS && a <= CNT_LAST_OFS) || (a >= REL_BASE_OFS && a <= REL_LAST_OFS));
   endfunction : reg_hit

   logic wr_en, rd_setup;
   logic [9:0] ctrl_reg;
   logic [7:0] evt_sel_reg, irq_status_reg, irq_mask_reg;
   logic [3:0] log_sel_reg;
   logic [STAMP_W-1:0] time_ms_reg;
   logic [REL_W-1:0] rel_time_reg [NUM_GROUPS];
   logic [31:0] cnt_reg [NUM_STATUS];

   assign wr_en = psel && penable && pwrite && reg_hit(paddr);
   assign rd_setup = psel && !penable && !pwrite;
   // Every access completes without wait states.
   assign pready = 1'b1;
   assign pslverr = psel && penable && !reg_hit(paddr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RESET;
         evt_sel_reg <= EVT_SEL_RESET;
         irq_mask_reg <= 8'h00;
         log_sel_reg <= 4'h0;
      end else begin
         // The two clear bits act once and read back as zero.
         ctrl_reg[CTRL_LOG_CLR_BIT:CTRL_CNT_CLR_BIT] <= 2'b00;
         if (wr_en) begin
            case (paddr)
               CTRL_OFS: ctrl_reg <= pwdata[9:0];
               EVT_SEL_OFS: evt_sel_reg <= pwdata[7:0];
               IRQ_MASK_OFS: irq_mask_reg <= pwdata[7:0];
               LOG_SEL_OFS: log_sel_reg <= pwdata[3:0];
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int g = 0; g < NUM_GROUPS; g++) begin
            rel_time_reg[g] <= REL_TIME_RESET_MS;
         end
      end else if (wr_en && paddr >= REL_BASE_OFS) begin
         rel_time_reg[paddr[4:2]] <= (pwdata > 32'(REL_TIME_MAX_MS)) ? REL_TIME_MAX_MS : pwdata[REL_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Millisecond time base
   // ----------------------------------------------------------------
   logic [TICK_W-1:0] tick_cnt_reg;
   logic ms_tick;

   assign ms_tick = (tick_cnt_reg == TICK_W'(MS_TICK_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= ms_tick ? '0 : tick_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         time_ms_reg <= '0;
      end else if (wr_en && paddr == TIME_MS_OFS) begin
         time_ms_reg <= pwdata;
      end else if (ms_tick) begin
         time_ms_reg <= time_ms_reg + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Input conditioning
   // ----------------------------------------------------------------
   logic [2:0] pins, sync1_reg, sync2_reg, sync3_reg, lvl_reg;
   logic arm_prev_reg, arm_lvl, blk_in, fcn, arm_rise;

   assign pins = {protection_start_input, inhibit_input_signal, arm_input_signal};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         sync3_reg <= 3'h0;
         lvl_reg <= 3'h0;
         arm_prev_reg <= 1'b0;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         lvl_reg <= (sync2_reg & sync3_reg) | (lvl_reg & (sync2_reg | sync3_reg));
         arm_prev_reg <= lvl_reg[0];
      end
   end

   assign arm_lvl = lvl_reg[0];
   assign blk_in = lvl_reg[1];
   assign fcn = lvl_reg[2];
   assign arm_rise = arm_lvl && !arm_prev_reg;

   // ----------------------------------------------------------------
   // Mode, blocking and forcing
   // ----------------------------------------------------------------
   mode_t mode_eff;
   force_t force_sel;
   logic blocked, arm_ok, forcing;

   assign mode_eff = ctrl_reg[CTRL_MODE_ALLOW_BIT] ? mode_t'(ctrl_reg[CTRL_MODE_LSB +: 3]) : MODE_ON;
   assign force_sel = force_t'(ctrl_reg[CTRL_FORCE_LSB +: 2]);
   assign forcing = ctrl_reg[CTRL_FORCE_EN_BIT] && force_sel != FORCE_NORMAL;
   assign blocked = blk_in || mode_eff == MODE_BLOCKED || mode_eff == MODE_TEST_BLOCKED;
   assign arm_ok = !blocked && (mode_eff == MODE_ON || mode_eff == MODE_TEST);

   // ----------------------------------------------------------------
   // Armed window and trip
   // ----------------------------------------------------------------
   win_t win_reg, win_next;
   logic [REL_W-1:0] elapsed_reg, sel_time, remain_now;
   logic expired;

   assign sel_time = rel_time_reg[setting_group];
   assign expired = elapsed_reg >= sel_time;
   assign remain_now = expired ? '0 : sel_time - elapsed_reg;

   always_comb begin
      win_next = win_reg;
      case (win_reg)
         WIN_IDLE: begin
            if (arm_rise && arm_ok) begin
               win_next = fcn ? WIN_TRIP : WIN_ARMED;
            end
         end
         WIN_ARMED: begin
            if (fcn) begin
               win_next = WIN_TRIP;
            end
         end
         WIN_TRIP: begin
            if (!fcn) begin
               win_next = WIN_ARMED;
            end
         end
         default: win_next = WIN_IDLE;
      endcase
      if (win_reg != WIN_IDLE) begin
         if (!arm_ok) begin
            win_next = WIN_IDLE;
         end else if (arm_rise) begin
            win_next = fcn ? WIN_TRIP : WIN_ARMED;
         end else if (expired) begin
            win_next = WIN_IDLE;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_reg <= WIN_IDLE;
      end else begin
         win_reg <= win_next;
      end
   end

   // A fresh edge while armed restarts the window from zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         elapsed_reg <= '0;
      end else if (win_next != WIN_IDLE && (win_reg == WIN_IDLE || arm_rise)) begin
         elapsed_reg <= '0;
      end else if (win_reg != WIN_IDLE && ms_tick && elapsed_reg != '1) begin
         elapsed_reg <= elapsed_reg + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Status, events and counters
   // ----------------------------------------------------------------
   logic [NUM_STATUS-1:0] stat_now, stat_prev_reg, ev_on, ev_off;
   logic [7:0] ev_all;
   logic cnt_clr;
   cond_t cond;

   always_comb begin
      stat_now[ST_INIT] = arm_lvl && mode_eff != MODE_OFF;
      stat_now[ST_BLOCK] = blocked;
      stat_now[ST_ACTIVE] = win_reg != WIN_IDLE;
      stat_now[ST_TRIP] = win_reg == WIN_TRIP;
      if (forcing) begin
         stat_now = '0;
         stat_now[ST_BLOCK] = force_sel == FORCE_BLOCKED;
         stat_now[ST_ACTIVE] = force_sel != FORCE_BLOCKED;
         stat_now[ST_TRIP] = force_sel == FORCE_TRIP;
      end
   end

   always_comb begin
      if (stat_now[ST_BLOCK]) begin
         cond = COND_BLOCKED;
      end else if (stat_now[ST_TRIP]) begin
         cond = COND_TRIP;
      end else if (stat_now[ST_ACTIVE]) begin
         cond = COND_ACTIVE;
      end else if (stat_now[ST_INIT]) begin
         cond = COND_INIT;
      end else begin
         cond = COND_NORMAL;
      end
   end

   assign ev_on = stat_now & ~stat_prev_reg;
   assign ev_off = ~stat_now & stat_prev_reg;
   assign ev_all = {ev_off, ev_on};
   assign cnt_clr = ctrl_reg[CTRL_CNT_CLR_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_prev_reg <= '0;
         event_strobe <= 8'h00;
         event_stamp <= '0;
      end else begin
         stat_prev_reg <= stat_now;
         event_strobe <= ev_all & evt_sel_reg;
         if (|ev_all) begin
            event_stamp <= time_ms_reg;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_STATUS; i++) begin
            cnt_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_STATUS; i++) begin
            if (cnt_clr) begin
               cnt_reg[i] <= '0;
            end else if (ev_on[i]) begin
               cnt_reg[i] <= cnt_reg[i] + 1'b1;
            end
         end
      end
   end

   // Events set sticky flags; a set in the clearing cycle wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= 8'h00;
         irq <= 1'b0;
      end else begin
         if (wr_en && paddr == IRQ_STATUS_OFS) begin
            irq_status_reg <= (irq_status_reg & ~pwdata[7:0]) | ev_all;
         end else begin
            irq_status_reg <= irq_status_reg | ev_all;
         end
         irq <= |((irq_status_reg | ev_all) & irq_mask_reg);
      end
   end

   // ----------------------------------------------------------------
   // Record log and pin outputs
   // ----------------------------------------------------------------
   logic [REC_W-1:0] rec_data;
   logic [CW-1:0] log_count;
   logic log_push;

   assign log_push = ev_on[ST_ACTIVE] || ev_on[ST_TRIP];

   record_log #(.WIDTH(REC_W), .DEPTH(LOG_DEPTH)) u_log (
      .pclk(pclk),
      .presetn(presetn),
      .push(log_push),
      .push_data({time_ms_reg, setting_group, ev_on[ST_TRIP], remain_now, elapsed_reg}),
      .clear(ctrl_reg[CTRL_LOG_CLR_BIT]),
      .rd_index(log_sel_reg),
      .rd_data(rec_data),
      .count(log_count)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         window_active_flag <= 1'b0;
         instant_trip_output <= 1'b0;
         block_condition_state <= COND_NORMAL;
         block_mode_readback <= MODE_ON;
         remaining_window_time <= '0;
      end else begin
         window_active_flag <= stat_now[ST_ACTIVE];
         // Outside forcing, test mode runs the logic but keeps the breaker untouched.
         instant_trip_output <= stat_now[ST_TRIP] && (forcing || mode_eff != MODE_TEST);
         block_condition_state <= cond;
         block_mode_readback <= mode_eff;
         remaining_window_time <= (win_reg != WIN_IDLE) ? remain_now : '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= 32'h0000_0000;
         if (paddr >= REL_BASE_OFS && paddr <= REL_LAST_OFS && paddr[1:0] == 2'b00) begin
            prdata <= 32'(rel_time_reg[paddr[4:2]]);
         end else if (paddr >= CNT_BASE_OFS && paddr <= CNT_LAST_OFS && paddr[1:0] == 2'b00) begin
            prdata <= cnt_reg[2'(paddr[5:2] - CNT_BASE_OFS[5:2])];
         end else begin
            case (paddr)
               CTRL_OFS: prdata <= 32'(ctrl_reg);
               STATUS_OFS: prdata <= {20'h0, stat_now, 1'b0, mode_eff, 1'b0, cond};
               EVT_SEL_OFS: prdata <= 32'(evt_sel_reg);
               IRQ_STATUS_OFS: prdata <= 32'(irq_status_reg);
               IRQ_MASK_OFS: prdata <= 32'(irq_mask_reg);
               TIME_MS_OFS: prdata <= time_ms_reg;
               LOG_SEL_OFS: prdata <= {11'h0, 5'(log_count), 3'h0, rec_data[2*REL_W],
                  1'b0, rec_data[2*REL_W+1 +: 3], 4'h0, log_sel_reg};
               LOG_STAMP_OFS: prdata <= rec_data[REC_W-1 -: STAMP_W];
               LOG_REMAIN_OFS: prdata <= 32'(rec_data[REL_W +: REL_W]);
               LOG_ELAPSED_OFS: prdata <= 32'(rec_data[REL_W-1:0]);
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   arm_starts_window_a: assert property (@(posedge pclk) disable iff (!presetn)
      win_reg == WIN_IDLE && arm_rise && arm_ok |=> win_reg != WIN_IDLE ##0 elapsed_reg == '0)
      else $error("Activate edge did not arm the window.");

   inhibit_holds_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      win_reg == WIN_IDLE && blocked |=> win_reg == WIN_IDLE)
      else $error("Window started while blocked.");

   trip_immediate_a: assert property (@(posedge pclk) disable iff (!presetn)
      win_reg == WIN_ARMED && fcn && arm_ok && !expired |=> win_reg == WIN_TRIP ##1 instant_trip_output
         || forcing || mode_eff == MODE_TEST)
      else $error("Function input inside the window did not trip.");

   trip_in_window_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(win_reg == WIN_TRIP) |-> $past(win_reg) == WIN_ARMED || $past(arm_rise && arm_ok))
      else $error("Trip arose outside the window.");

   window_expiry_a: assert property (@(posedge pclk) disable iff (!presetn)
      win_reg != WIN_IDLE && expired && arm_ok && !arm_rise |=> win_reg == WIN_IDLE ##2 !window_active_flag
         || forcing)
      else $error("Window outlived its release time.");

   event_select_a: assert property (@(posedge pclk) disable iff (!presetn)
      ev_on[ST_ACTIVE] |=> event_strobe[ST_ACTIVE] == $past(evt_sel_reg[ST_ACTIVE]) && event_stamp == $past(time_ms_reg))
      else $error("Active ON event strobe or stamp wrong.");

   counter_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      ev_on[ST_TRIP] && !cnt_clr |=> cnt_reg[ST_TRIP] == $past(cnt_reg[ST_TRIP]) + 32'h1)
      else $error("Trip counter did not advance.");

   mode_default_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_reg[CTRL_MODE_ALLOW_BIT] |=> block_mode_readback == MODE_ON)
      else $error("Mode moved while individual mode is not allowed.");

   irq_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
      ev_all[ST_TRIP] && irq_mask_reg[ST_TRIP] |=> irq && irq_status_reg[ST_TRIP])
      else $error("Masked-in event did not raise the interrupt.");

endmodule : switch_onto_fault

// ### tb/breaker_side.sv
`timescale 1ns/100ps
module breaker_side (
   input logic pclk,
   input logic close_cmd,
   input logic start_cmd,
   output logic arm_input_signal,
   output logic protection_start_input
);
   // Breaker close and stage start are plain levels that change only after a clock edge.
   always_ff @(posedge pclk) begin
      arm_input_signal <= close_cmd;
      protection_start_input <= start_cmd;
   end
endmodule : breaker_side

// ### tb/tb_switch_onto_fault.sv
`timescale 1ns/100ps
module tb_switch_onto_fault
   import switch_onto_fault_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h00013f45;
   logic arm, fstart, close_cmd = 0, start_cmd = 0, inhibit = 0, act, trip, err;
   logic [7:0] ev;
   logic [20:0] rem;
   logic [31:0] stamp;
   logic [2:0] grp = 3'h0, cond, mode;
   int err_count = 0, num_checks = 0;
   always #12.5 pclk = ~pclk;
   breaker_side u_far (.pclk(pclk), .close_cmd(close_cmd), .start_cmd(start_cmd),
      .arm_input_signal(arm), .protection_start_input(fstart));
   switch_onto_fault #(.MS_TICK_CYCLES(10)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .arm_input_signal(arm),
      .inhibit_input_signal(inhibit), .protection_start_input(fstart), .setting_group(grp),
      .window_active_flag(act), .instant_trip_output(trip), .block_condition_state(cond),
      .block_mode_readback(mode), .remaining_window_time(rem), .event_strobe(ev), .event_stamp(stamp));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [31:0] clamp(input logic [31:0] v);
      return (v > REL_TIME_MAX_MS) ? REL_TIME_MAX_MS : v;
   endfunction : clamp
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic await(ref logic s, input logic v, input int n);
      // Outputs are read at the edge, before the design updates them, so they are settled values.
      for (int i = 0; i < n && s !== v; i++) @(posedge pclk);
   endtask : await
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (5000) @(posedge pclk);
      err_count++;
      wrap_up();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      apb(0, EVT_SEL_OFS, 0); chk("evt_sel", 32'hff, rd);
      apb(0, REL_BASE_OFS, 0); chk("rel_default", 1000, rd);
      chk("mode", MODE_ON, mode);
      apb(0, 8'hfc, 0); chk("unmapped", 1, err);
      for (int k = 0; k < 6; k++) begin
         seed = xs(seed);
         apb(1, REL_BASE_OFS + {seed[2:0], 2'b00}, seed % 2100000);
         apb(0, REL_BASE_OFS + {seed[2:0], 2'b00}, 0); chk("rel", clamp(seed % 2100000), rd);
      end
      apb(1, REL_BASE_OFS + 8'h04, 5);
      apb(1, REL_BASE_OFS + 8'h08, 2);
      apb(1, IRQ_MASK_OFS, 32'h4);
      grp <= 3'h1;
      close_cmd <= 1;
      await(act, 1, 20); chk("armed", 1, act);
      chk("act_on_strobe", 1, ev[ST_ACTIVE]);
      chk("remain", 5, rem);
      chk("irq_set", 1, irq);
      apb(1, IRQ_STATUS_OFS, 32'h4);
      await(irq, 0, 3); chk("irq_clr", 0, irq);
      start_cmd <= 1;
      await(trip, 1, 12); chk("trip", 1, trip);
      chk("cond_trip", COND_TRIP, cond);
      start_cmd <= 0;
      close_cmd <= 0;
      await(act, 0, 120);
      grp <= 3'h2;
      close_cmd <= 1;
      await(act, 1, 20);
      close_cmd <= 0;
      await(act, 0, 60); chk("expired", 0, act);
      chk("cond_normal", COND_NORMAL, cond);
      start_cmd <= 1;
      repeat (14) @(posedge pclk);
      chk("no_trip", 0, trip);
      start_cmd <= 0;
      inhibit <= 1;
      repeat (6) @(posedge pclk);
      close_cmd <= 1;
      repeat (20) @(posedge pclk);
      chk("blocked", 0, act);
      chk("cond_blk", COND_BLOCKED, cond);
      apb(0, CNT_BASE_OFS + 8'h08, 0); chk("act_cnt", 2, rd);
      apb(0, LOG_SEL_OFS, 0); chk("log_count", 3, rd[20:16]);
      chk("log_group", 2, rd[10:8]);
      apb(0, LOG_REMAIN_OFS, 0); chk("log_remain", 2, rd);
      apb(1, LOG_SEL_OFS, 1);
      apb(0, LOG_SEL_OFS, 0); chk("log_trip", 1, rd[12]);
      chk("log_trip_grp", 1, rd[10:8]);
      apb(1, CTRL_OFS, 32'h100);
      apb(0, CNT_BASE_OFS + 8'h08, 0); chk("cnt_clr", 0, rd);
      apb(1, TIME_MS_OFS, 32'h100);
      apb(1, CTRL_OFS, 32'h62);
      repeat (2) @(posedge pclk);
      chk("forced_trip", 1, trip);
      chk("forced_cond", COND_TRIP, cond);
      chk("trip_on_strobe", 1, ev[ST_TRIP]);
      chk("stamp", 1, (stamp - 32'h100) <= 32'h1);
      wrap_up();
   end
endmodule : tb_switch_onto_fault
